// ---- core/dtd_defs.svh ----
// register offsets, field codes and timing counts of the dual timer
// ==========================================================
// Summary of operation
// - transmit start drives wide output to its initial level, normal or ping-pong only
// - wide timer disabled: output is the inverse of its initial level, normal or ping-pong only
// - demodulation: falling edge sets shared bit, write 1 clears it
// - wide control bit 7 reads and writes the run enable, resets 0
// - transmit bit 6: 0 reloads at terminal count, 1 stops
// - demodulation bit 6: 0 captures every edge, 1 only the first
// - wide timeout flag set at terminal count, write 1 clears
// - bits 4:3 divide count clock by 1,2,4,8, kept over stop recovery
// - bit 2 enables capture interrupt, bit 1 timeout interrupt
// - bit 0 puts wide output on its pin instead of port data, transmit only; demodulation keeps port data
// - sync register mirrors both enables, bit 5 sync mode, bits 4:0 read ones
// - edge detector pulses on selected edges of the chosen input pin
// - pulses shorter than the glitch width are removed before detection
// - narrow timer disabled: output is the inverse of its initial level
// - narrow start: output takes initial level, loads low or high reload
// - single pass: count to zero, stop, toggle, set timeout, maybe interrupt
// - modulo-N: toggle and reload each end, timeout every second end; the wide timer here sets its timeout at every end
// - reload registers may change anytime, used at the next load
// - count of 1 is unsupported, count of 0 runs full range
// - ping-pong: hardware swaps enables, each end sets its timeout
// - port interrupt source is the pin or recovery source per mode bit 1
// - submode 10 forces wide output 0, 11 forces 1
// - glitch field: none, 4 cycles, 8 cycles, 11 reserved
`ifndef DTD_DEFS_SVH
`define DTD_DEFS_SVH
`define DTD_OFF_NCTL   8'h00
`define DTD_OFF_CCTL   8'h01
`define DTD_OFF_WCTL   8'h02
`define DTD_OFF_SYNC   8'h03
`define DTD_OFF_NRH    8'h04
`define DTD_OFF_NRL    8'h05
`define DTD_OFF_WRH    8'h06
`define DTD_OFF_WRL    8'h07
`define DTD_OFF_WCAPL  8'h08
`define DTD_OFF_WCAPH  8'h09
`define DTD_OFF_P3M    8'h0a
`define DTD_SYNC_ONES  5'h1f
`define DTD_N_TC       8'h01
`define DTD_W_TC       16'h0001
`define DTD_SUB_PP     2'h1
`define DTD_SUB_F0     2'h2
`define DTD_SUB_F1     2'h3
`define DTD_GF_4       2'h1
`define DTD_GF_8       2'h2
`define DTD_GLITCH4    4'h4
`define DTD_GLITCH8    4'h8
`endif

// ---- core/dtd_pkg.sv ----
// types shared by the dual timer block
package dtd_pkg;
   typedef logic [7:0] dtd_byte_t;
   // layout of both timer control registers
   typedef struct packed {
      logic       en;
      logic       single;
      logic       timeout;
      logic [1:0] clk_sel;
      logic       cap_mask;
      logic       to_mask;
      logic       pin_sel;
   } dtd_tctl_t;
   // layout of the common control register
   typedef struct packed {
      logic       demod;
      logic       pin_sel;
      logic [1:0] logic_edge;
      logic [1:0] sub_glitch;
      logic       init_n;
      logic       init_w;
   } dtd_cctl_t;
   typedef struct packed {
      logic       w_en;
      logic       n_en;
      logic       sync;
      logic [4:0] ones;
   } dtd_sync_t;
endpackage

// ---- core/dtd_timer.sv ----
// dual 8/16-bit counter timer with transmit and demodulation modes
`timescale 1ns/1ps
`default_nettype none
`include "dtd_defs.svh"
module dtd_timer
(
   input  wire logic              clock_i,
   input  wire logic              rstn_i,
   input  wire logic              stop_recover_i,
   input  wire dtd_pkg::dtd_byte_t addr_i,
   input  wire dtd_pkg::dtd_byte_t wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output var  dtd_pkg::dtd_byte_t rdata_o,
   input  wire logic              port3_line1_i,
   input  wire logic              port2_line0_i,
   input  wire logic              port3_line3_i,
   input  wire logic              smr_source_i,
   input  wire logic              port3_line5_data_i,
   input  wire logic              port3_line6_data_i,
   output logic                   port3_line5_o,
   output logic                   port3_line6_o,
   output logic                   wide_timeout_irq_o,
   output logic                   wide_capture_irq_o,
   output logic                   narrow_timeout_irq_o,
   output logic                   port_irq_o
);
   import dtd_pkg::*;

   // ==========================================================
   // pin synchronisers
   logic [3:0] in_s1_q;
   logic [3:0] in_s2_q;
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         in_s1_q <= 4'h0;
         in_s2_q <= 4'h0;
      end
      else
      begin
         in_s1_q <= {smr_source_i, port3_line3_i, port2_line0_i, port3_line1_i};
         in_s2_q <= in_s1_q;
      end
   end

   // ==========================================================
   // register state
   logic       n_en_q, n_single_q, n_to_q, n_capm_q, n_tom_q;
   logic [1:0] n_clk_q;
   logic       w_en_q, w_single_q, w_to_q, w_capm_q, w_tom_q, w_pin_q;
   logic [1:0] w_clk_q;
   dtd_cctl_t  cc_q;
   logic       sync_q, p3m_q;
   logic       rise_q, fall_q;
   dtd_byte_t  nrh_q, nrl_q, wrh_q, wrl_q, capl_q, caph_q;
   dtd_tctl_t  wd_t;
   dtd_cctl_t  wd_c;
   dtd_sync_t  wd_s;
   logic       wr_n, wr_c, wr_w, wr_s;
   logic       pp, demod;

   always_comb
   begin
      wd_t = dtd_tctl_t'(wdata_i);
      wd_c = dtd_cctl_t'(wdata_i);
      wd_s = dtd_sync_t'(wdata_i);
      wr_n = wr_i && (addr_i == `DTD_OFF_NCTL);
      wr_c = wr_i && (addr_i == `DTD_OFF_CCTL);
      wr_w = wr_i && (addr_i == `DTD_OFF_WCTL);
      wr_s = wr_i && (addr_i == `DTD_OFF_SYNC);
      demod = cc_q.demod;
      pp = !demod && (cc_q.sub_glitch == `DTD_SUB_PP);
   end

   // ==========================================================
   // prescaler, shared free counter
   logic [2:0] pre_q;
   logic       n_tick, w_tick;
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
         pre_q <= 3'h0;
      else
         pre_q <= pre_q + 3'h1;
   end

   function automatic logic tick_of(input logic [1:0] sel, input logic [2:0] p);
      case (sel)
         2'h0:    tick_of = 1'b1;
         2'h1:    tick_of = (p[0] == 1'b0);
         2'h2:    tick_of = (p[1:0] == 2'h0);
         default: tick_of = (p == 3'h0);
      endcase
   endfunction

   always_comb
   begin
      w_tick = tick_of(w_clk_q, pre_q);
      n_tick = tick_of(n_clk_q, pre_q);
   end

   // ==========================================================
   // configuration fields
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         n_single_q <= 1'b0;
         n_tom_q    <= 1'b0;
         w_single_q <= 1'b0;
         w_tom_q    <= 1'b0;
         w_pin_q    <= 1'b0;
         cc_q       <= dtd_cctl_t'(8'h00);
      end
      else if (stop_recover_i)
      begin
         n_single_q <= 1'b0;
         n_tom_q    <= 1'b0;
         w_single_q <= 1'b0;
         w_tom_q    <= 1'b0;
         w_pin_q    <= 1'b0;
         cc_q       <= dtd_cctl_t'(8'h00);
      end
      else
      begin
         if (wr_n)
         begin
            n_single_q <= wd_t.single;
            n_tom_q    <= wd_t.to_mask;
         end
         if (wr_w)
         begin
            w_single_q <= wd_t.single;
            w_tom_q    <= wd_t.to_mask;
            w_pin_q    <= wd_t.pin_sel;
         end
         if (wr_c)
         begin
            cc_q.demod      <= wd_c.demod;
            cc_q.pin_sel    <= wd_c.pin_sel;
            cc_q.logic_edge <= wd_c.logic_edge;
            cc_q.sub_glitch <= wd_c.sub_glitch;
            // initial levels only writable in transmit; in demod these are flags
            if (!demod)
            begin
               cc_q.init_n <= wd_c.init_n;
               cc_q.init_w <= wd_c.init_w;
            end
         end
      end
   end

   // fields that survive stop recovery
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         n_clk_q  <= 2'h0;
         n_capm_q <= 1'b0;
         w_clk_q  <= 2'h0;
         w_capm_q <= 1'b0;
         sync_q   <= 1'b0;
         p3m_q    <= 1'b0;
      end
      else
      begin
         if (wr_n)
         begin
            n_clk_q  <= wd_t.clk_sel;
            n_capm_q <= wd_t.cap_mask;
         end
         if (wr_w)
         begin
            w_clk_q  <= wd_t.clk_sel;
            w_capm_q <= wd_t.cap_mask;
         end
         if (wr_s)
            sync_q <= wd_s.sync;
         if (wr_i && (addr_i == `DTD_OFF_P3M))
            p3m_q <= wdata_i[1];
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         nrh_q <= 8'h00;
         nrl_q <= 8'h00;
         wrh_q <= 8'h00;
         wrl_q <= 8'h00;
      end
      else
      begin
         if (wr_i && (addr_i == `DTD_OFF_NRH))
            nrh_q <= wdata_i;
         if (wr_i && (addr_i == `DTD_OFF_NRL))
            nrl_q <= wdata_i;
         if (wr_i && (addr_i == `DTD_OFF_WRH))
            wrh_q <= wdata_i;
         if (wr_i && (addr_i == `DTD_OFF_WRL))
            wrl_q <= wdata_i;
      end
   end

   // ==========================================================
   // glitch filter and edge detector
   logic       raw, filt_q, filt_d1_q;
   logic [3:0] gcnt_q;
   logic [3:0] glen;
   logic       pos_e, neg_e, edge_sel;
   always_comb
   begin
      raw = cc_q.pin_sel ? in_s2_q[1] : in_s2_q[0];
      case (cc_q.sub_glitch)
         `DTD_GF_4: glen = `DTD_GLITCH4;
         `DTD_GF_8: glen = `DTD_GLITCH8;
         default:   glen = 4'h0;
      endcase
   end

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         filt_q    <= 1'b0;
         filt_d1_q <= 1'b0;
         gcnt_q    <= 4'h0;
      end
      else
      begin
         filt_d1_q <= filt_q;
         if (glen == 4'h0 || raw == filt_q)
         begin
            gcnt_q <= 4'h0;
            filt_q <= raw;
         end
         else if (gcnt_q == glen - 4'h1)
         begin
            gcnt_q <= 4'h0;
            filt_q <= raw;
         end
         else
            gcnt_q <= gcnt_q + 4'h1;
      end
   end

   always_comb
   begin
      pos_e = demod && filt_q && !filt_d1_q;
      neg_e = demod && !filt_q && filt_d1_q;
      case (cc_q.logic_edge)
         2'h0:    edge_sel = neg_e;
         2'h1:    edge_sel = pos_e;
         2'h2:    edge_sel = pos_e || neg_e;
         default: edge_sel = 1'b0;
      endcase
   end

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rise_q <= 1'b0;
         fall_q <= 1'b0;
      end
      else if (stop_recover_i)
      begin
         rise_q <= 1'b0;
         fall_q <= 1'b0;
      end
      else
      begin
         // falling flag, set wins over clear
         if (neg_e)
            fall_q <= 1'b1;
         else if (wr_c && demod && wd_c.init_w)
            fall_q <= 1'b0;
         if (pos_e)
            rise_q <= 1'b1;
         else if (wr_c && demod && wd_c.init_n)
            rise_q <= 1'b0;
      end
   end

   // ==========================================================
   // narrow timer, plus start and terminal count strobes of both timers and the wide capture strobe
   logic [7:0] n_cnt_q;
   logic       n_out_q, n_half_q, n_en_d1_q;
   logic       n_start, n_tc;
   logic [15:0] w_cnt_q;
   logic        w_out_q, w_en_d1_q, w_ign_q;
   logic        w_start, w_tc, w_cap;
   always_comb
   begin
      n_start = n_en_q && !n_en_d1_q;
      n_tc    = n_en_q && !n_start && n_tick && (n_cnt_q == `DTD_N_TC);
      w_start = w_en_q && !w_en_d1_q;
      w_tc    = w_en_q && !w_start && w_tick && (w_cnt_q == `DTD_W_TC);
      w_cap   = w_en_q && !w_start && edge_sel && !w_ign_q;
   end

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         n_cnt_q   <= 8'h00;
         n_out_q   <= 1'b0;
         n_half_q  <= 1'b0;
         n_en_d1_q <= 1'b0;
      end
      else
      begin
         n_en_d1_q <= n_en_q;
         if (n_start)
         begin
            n_out_q  <= cc_q.init_n;
            n_cnt_q  <= cc_q.init_n ? nrh_q : nrl_q;
            n_half_q <= 1'b0;
         end
         else if (n_tc)
         begin
            n_out_q  <= !n_out_q;
            n_cnt_q  <= n_out_q ? nrl_q : nrh_q;
            n_half_q <= !n_half_q;
         end
         else if (n_en_q && n_tick)
            n_cnt_q <= n_cnt_q - 8'h01;
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
         n_to_q <= 1'b0;
      else if (n_tc && (n_single_q || n_half_q))
         n_to_q <= 1'b1;
      else if (stop_recover_i || (wr_n && wd_t.timeout))
         n_to_q <= 1'b0;
   end

   // software order assumed; hardware just follows enables
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
         n_en_q <= 1'b0;
      else if (stop_recover_i)
         n_en_q <= 1'b0;
      else if (wr_n)
         n_en_q <= wd_t.en;
      else if (wr_s)
         n_en_q <= wd_s.n_en;
      else if (n_tc && n_single_q)
         n_en_q <= 1'b0;
      else if (pp && w_tc)
         n_en_q <= 1'b1;
   end

   // ==========================================================
   // wide timer
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         w_cnt_q   <= 16'h0000;
         w_out_q   <= 1'b0;
         w_en_d1_q <= 1'b0;
         w_ign_q   <= 1'b0;
         capl_q    <= 8'h00;
         caph_q    <= 8'h00;
      end
      else
      begin
         w_en_d1_q <= w_en_q;
         if (w_start)
         begin
            w_out_q <= cc_q.init_w;
            w_cnt_q <= {wrh_q, wrl_q};
            w_ign_q <= 1'b0;
         end
         else if (w_cap)
         begin
            {caph_q, capl_q} <= w_cnt_q;
            w_cnt_q <= {wrh_q, wrl_q};
            w_ign_q <= w_single_q;
         end
         else if (w_tc)
         begin
            // reload; single pass stops via enable
            w_out_q <= !w_out_q;
            w_cnt_q <= {wrh_q, wrl_q};
         end
         else if (w_en_q && w_tick)
            w_cnt_q <= w_cnt_q - 16'h0001;
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
         w_to_q <= 1'b0;
      else if (w_tc)
         w_to_q <= 1'b1;
      else if (stop_recover_i || (wr_w && wd_t.timeout))
         w_to_q <= 1'b0;
   end

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
         w_en_q <= 1'b0;
      else if (stop_recover_i)
         w_en_q <= 1'b0;
      else if (wr_w)
         w_en_q <= wd_t.en;
      else if (wr_s)
         w_en_q <= wd_s.w_en;
      else if (w_tc && w_single_q && !demod)
         w_en_q <= 1'b0;
      else if (pp && n_tc)
         w_en_q <= 1'b1;
   end

   // ==========================================================
   // output levels and pins
   logic n_lvl, w_lvl, comb;
   always_comb
   begin
      // idle inverse level
      // start cycle shows the initial level at once, the stored level is still stale
      n_lvl = n_start ? cc_q.init_n : (n_en_q ? n_out_q : !cc_q.init_n);
      w_lvl = w_start ? cc_q.init_w : (w_en_q ? w_out_q : !cc_q.init_w);
      if (cc_q.sub_glitch == `DTD_SUB_F0)
         w_lvl = 1'b0;
      else if (cc_q.sub_glitch == `DTD_SUB_F1)
         w_lvl = 1'b1;
      case (cc_q.logic_edge)
         2'h0:    comb = n_lvl & w_lvl;
         2'h1:    comb = n_lvl | w_lvl;
         2'h2:    comb = !(n_lvl | w_lvl);
         default: comb = !(n_lvl & w_lvl);
      endcase
   end

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         port3_line5_o        <= 1'b0;
         port3_line6_o        <= 1'b0;
         wide_timeout_irq_o   <= 1'b0;
         wide_capture_irq_o   <= 1'b0;
         narrow_timeout_irq_o <= 1'b0;
         port_irq_o           <= 1'b0;
      end
      else
      begin
         port3_line5_o <= (w_pin_q && !demod) ? w_lvl : port3_line5_data_i;
         port3_line6_o <= (cc_q.pin_sel && !demod) ? comb : port3_line6_data_i;
         wide_timeout_irq_o   <= w_tc && w_tom_q;
         wide_capture_irq_o   <= w_cap && w_capm_q;
         narrow_timeout_irq_o <= n_tc && (n_single_q || n_half_q) && n_tom_q;
         port_irq_o <= p3m_q ? in_s2_q[3] : in_s2_q[2];
      end
   end

   // ==========================================================
   // read port, data one cycle after the strobe
   dtd_byte_t rd_d;
   always_comb
   begin
      case (addr_i)
         `DTD_OFF_NCTL:  rd_d = {n_en_q, n_single_q, n_to_q, n_clk_q,
                                 n_capm_q, n_tom_q, 1'b0};
         `DTD_OFF_CCTL:  rd_d = {cc_q[7:2], demod ? {rise_q, fall_q}
                                                  : {cc_q.init_n, cc_q.init_w}};
         `DTD_OFF_WCTL:  rd_d = {w_en_q, w_single_q, w_to_q, w_clk_q,
                                 w_capm_q, w_tom_q, w_pin_q};
         `DTD_OFF_SYNC:  rd_d = {w_en_q, n_en_q, sync_q, `DTD_SYNC_ONES};
         `DTD_OFF_NRH:   rd_d = nrh_q;
         `DTD_OFF_NRL:   rd_d = nrl_q;
         `DTD_OFF_WRH:   rd_d = wrh_q;
         `DTD_OFF_WRL:   rd_d = wrl_q;
         `DTD_OFF_WCAPL: rd_d = capl_q;
         `DTD_OFF_WCAPH: rd_d = caph_q;
         `DTD_OFF_P3M:   rd_d = {6'h00, p3m_q, 1'b0};
         default:        rd_d = 8'h00;
      endcase
   end

   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
         rdata_o <= 8'h00;
      else if (rd_i)
         rdata_o <= rd_d;
      else
         rdata_o <= 8'h00;
   end
endmodule
`default_nettype wire

// ---- dv/dtd_timer_sva.sv ----
// assertion checker for the dual timer ports
`timescale 1ns/1ps
`default_nettype none
`include "dtd_defs.svh"
module dtd_timer_sva
(
   input wire logic               clock_i,
   input wire logic               rstn_i,
   input wire logic               stop_recover_i,
   input wire dtd_pkg::dtd_byte_t addr_i,
   input wire dtd_pkg::dtd_byte_t wdata_i,
   input wire logic               wr_i,
   input wire logic               rd_i,
   input wire dtd_pkg::dtd_byte_t rdata_o,
   input wire logic               port3_line5_data_i,
   input wire logic               port3_line5_o,
   input wire logic               wide_timeout_irq_o,
   input wire logic               wide_capture_irq_o,
   input wire logic               narrow_timeout_irq_o
);
   import dtd_pkg::*;
   logic      up_q;
   logic      pin_sel_q;
   logic      wmask_q;
   logic      cmask_q;
   logic      nmask_q;
   dtd_byte_t cctl_q;
   // ==========================================================
   // shadow of software fields
   // capture mask survives stop recovery, so it is not cleared there
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         up_q      <= 1'b0;
         pin_sel_q <= 1'b0;
         wmask_q   <= 1'b0;
         cmask_q   <= 1'b0;
         nmask_q   <= 1'b0;
         cctl_q    <= 8'h00;
      end
      else
      begin
         up_q <= 1'b1;
         if (stop_recover_i)
         begin
            pin_sel_q <= 1'b0;
            wmask_q   <= 1'b0;
            nmask_q   <= 1'b0;
            cctl_q    <= 8'h00;
         end
         else if (wr_i && addr_i == `DTD_OFF_WCTL)
         begin
            pin_sel_q <= wdata_i[0];
            wmask_q   <= wdata_i[1];
            cmask_q   <= wdata_i[2];
         end
         else if (wr_i && addr_i == `DTD_OFF_NCTL)
            nmask_q <= wdata_i[1];
         else if (wr_i && addr_i == `DTD_OFF_CCTL)
            cctl_q <= wdata_i;
      end
   end
   // ==========================================================
   // properties
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   sequence s_quiet;
      !wr_i && !stop_recover_i;
   endsequence
   sequence s_wstop;
      wr_i && addr_i == `DTD_OFF_WCTL && !wdata_i[7] && wdata_i[0] && !stop_recover_i
         && !cctl_q[7] && !cctl_q[3];
   endsequence
   sequence s_wstart;
      wr_i && addr_i == `DTD_OFF_WCTL && wdata_i[7] && wdata_i[0] && !stop_recover_i
         && !cctl_q[7] && !cctl_q[3];
   endsequence
   sequence s_force;
      wr_i && addr_i == `DTD_OFF_CCTL && wdata_i[7:3] == 5'h01 && pin_sel_q
         && !stop_recover_i;
   endsequence
   AST_RD_IDLE: assert property (!rd_i |=> rdata_o == 8'h00)
      else $error("read data not zero outside its slot");
   AST_SYNC_ONES: assert property (rd_i && addr_i == `DTD_OFF_SYNC |=> rdata_o[4:0] == 5'h1f)
      else $error("sync low bits not all ones");
   AST_SYNC_EN: assert property (s_wstart ##1 s_quiet ##1 s_quiet
      ##1 (rd_i && addr_i == `DTD_OFF_SYNC && !stop_recover_i) |=> rdata_o[7])
      else $error("sync register misses wide enable");
   AST_P5_PORT: assert property (up_q && !$past(pin_sel_q) |-> port3_line5_o == $past(port3_line5_data_i))
      else $error("pin does not follow port data");
   AST_P5_IDLE: assert property (s_wstop ##1 s_quiet |=> port3_line5_o == !cctl_q[0])
      else $error("idle wide output not inverse of initial level");
   AST_P5_START: assert property (s_wstop ##1 s_quiet ##1 s_quiet ##1 s_wstart
      ##1 s_quiet |=> port3_line5_o == cctl_q[0])
      else $error("wide output not at initial level on start");
   AST_FORCE_LO: assert property (s_force ##0 !wdata_i[2] ##1 s_quiet |=> !port3_line5_o)
      else $error("forced low not seen");
   AST_FORCE_HI: assert property (s_force ##0 wdata_i[2] ##1 s_quiet |=> port3_line5_o)
      else $error("forced high not seen");
   AST_WIRQ_MASK: assert property (wide_timeout_irq_o |-> $past(wmask_q))
      else $error("wide timeout interrupt while masked");
   AST_CIRQ_MASK: assert property (wide_capture_irq_o |-> $past(cmask_q))
      else $error("capture interrupt while masked");
   AST_NIRQ_MASK: assert property (narrow_timeout_irq_o |-> $past(nmask_q))
      else $error("narrow timeout interrupt while masked");
endmodule
bind dtd_timer dtd_timer_sva u_dtd_timer_sva (.*);
`default_nettype wire

// ---- dv/dtd_pin_model.sv ----
// far-side model of the demodulator input line
`timescale 1ns/1ps
`default_nettype none
module dtd_pin_model
(
   input  wire logic       clock_i,
   input  wire logic       go_i,
   input  wire logic [7:0] len_i,
   output var  logic       pin_o
);
   logic [7:0] cnt_q = 8'h00;
   // ==========================================================
   // low pulse of len_i clocks
   // line rests high on its pull-up between pulses
   always_ff @(posedge clock_i)
   begin
      if (go_i)
         cnt_q <= len_i;
      else if (cnt_q != 8'h00)
         cnt_q <= cnt_q - 8'h01;
   end
   assign pin_o = (cnt_q == 8'h00);
endmodule
`default_nettype wire

// ---- dv/tb_dtd_timer.sv ----
// self-checking bench for the dual timer
`timescale 1ns/1ps
`default_nettype none
`include "dtd_defs.svh"
module tb_dtd_timer;
   import dtd_pkg::*;
   logic      clock_i = 1'b0;
   logic      rstn_i  = 1'b0;
   logic      stop_i  = 1'b0;
   dtd_byte_t addr_i  = 8'h00;
   dtd_byte_t wdata_i = 8'h00;
   logic      wr_i    = 1'b0;
   logic      rd_i    = 1'b0;
   logic      go      = 1'b0;
   logic [7:0] len    = 8'h00;
   logic      p33     = 1'b1;
   logic      smr     = 1'b0;
   logic      p35d    = 1'b1;
   dtd_byte_t rdata_o;
   logic      p31;
   logic      p35;
   logic      p36;
   logic      wto;
   logic      wcap;
   logic      nto;
   logic      pirq;
   int        n_mismatch = 0;
   int        samples_checked = 0;
   localparam logic [23:0] ROWS [6] = '{24'h021e1e, 24'h023e1e, 24'h03203f,
                                         24'h030a1f, 24'h04a5a5, 24'h30ff00};
   always #50 clock_i = ~clock_i;
   dtd_timer u_dtd_timer (.clock_i(clock_i), .rstn_i(rstn_i), .stop_recover_i(stop_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .port3_line1_i(p31), .port2_line0_i(1'b1), .port3_line3_i(p33), .smr_source_i(smr),
      .port3_line5_data_i(p35d), .port3_line6_data_i(1'b0), .port3_line5_o(p35),
      .port3_line6_o(p36), .wide_timeout_irq_o(wto), .wide_capture_irq_o(wcap),
      .narrow_timeout_irq_o(nto), .port_irq_o(pirq));
   dtd_pin_model u_dtd_pin_model (.clock_i(clock_i), .go_i(go), .len_i(len), .pin_o(p31));
   // ==========================================================
   // tasks
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input dtd_byte_t got, input dtd_byte_t exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one strobe per access, a free cycle after it
   task automatic bus(input logic w, input dtd_byte_t a, input dtd_byte_t d,
                      output dtd_byte_t q);
      @(posedge clock_i);
      wr_i    <= w;
      rd_i    <= !w;
      addr_i  <= a;
      wdata_i <= d;
      @(posedge clock_i);
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      @(negedge clock_i);
      q = rdata_o;
   endtask
   task automatic wr(input dtd_byte_t a, input dtd_byte_t d);
      dtd_byte_t q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rc(input dtd_byte_t a, input dtd_byte_t m, input dtd_byte_t e);
      dtd_byte_t q;
      bus(1'b0, a, 8'h00, q);
      chk(q & m, e);
   endtask
   task automatic pulse(input logic [7:0] l);
      @(posedge clock_i);
      go  <= 1'b1;
      len <= l;
      @(posedge clock_i);
      go  <= 1'b0;
   endtask
   task automatic wait_irq(input int sel, output int n);
      logic v;
      n = 0;
      v = 1'b0;
      while (!v && n < 300)
      begin
         @(negedge clock_i);
         n++;
         v = ((sel == 0) ? wto : (sel == 1) ? wcap : nto) === 1'b1;
      end
      if (!v)
      begin
         n_mismatch++;
         end_of_test();
      end
   endtask
   // ==========================================================
   // main sequence
   initial
   begin
      int n;
      repeat (2) @(posedge clock_i);
      rstn_i <= 1'b1;
      rc(`DTD_OFF_WCTL, 8'hff, 8'h00);
      rc(`DTD_OFF_SYNC, 8'hff, 8'h1f);
      for (int i = 0; i < 6; i++)
      begin
         wr(ROWS[i][23:16], ROWS[i][15:8]);
         rc(ROWS[i][23:16], 8'hff, ROWS[i][7:0]);
      end
      wr(`DTD_OFF_WCTL, 8'h1a);
      @(posedge clock_i);
      stop_i <= 1'b1;
      @(posedge clock_i);
      stop_i <= 1'b0;
      rc(`DTD_OFF_WCTL, 8'hff, 8'h18);
      // full-range reload keeps the wide timer quiet meanwhile
      wr(`DTD_OFF_WRH, 8'h00);
      wr(`DTD_OFF_WRL, 8'h00);
      wr(`DTD_OFF_CCTL, 8'h01);
      wr(`DTD_OFF_WCTL, 8'h01);
      @(negedge clock_i);
      chk({7'h00, p35}, 8'h00);
      wr(`DTD_OFF_WCTL, 8'h81);
      @(negedge clock_i);
      chk({7'h00, p35}, 8'h01);
      rc(`DTD_OFF_SYNC, 8'h80, 8'h80);
      for (int f = 0; f < 2; f++)
      begin
         wr(`DTD_OFF_CCTL, 8'h09 | 8'(f << 2));
         @(negedge clock_i);
         chk({7'h00, p35}, 8'(f));
      end
      wr(`DTD_OFF_WCTL, 8'h01);
      wr(`DTD_OFF_WCTL, 8'h00);
      @(posedge clock_i);
      p35d <= 1'b0;
      repeat (2) @(negedge clock_i);
      chk({7'h00, p35}, 8'h00);
      wr(`DTD_OFF_WRL, 8'h04);
      wr(`DTD_OFF_WCTL, 8'hc2);
      wait_irq(0, n);
      rc(`DTD_OFF_WCTL, 8'hff, 8'h62);
      wr(`DTD_OFF_WCTL, 8'h62);
      rc(`DTD_OFF_WCTL, 8'hff, 8'h42);
      // narrow halves of 3 and 5 ticks, one timeout per full cycle
      wr(`DTD_OFF_NRL, 8'h03);
      wr(`DTD_OFF_NRH, 8'h05);
      wr(`DTD_OFF_CCTL, 8'h00);
      wr(`DTD_OFF_NCTL, 8'h82);
      wait_irq(2, n);
      wait_irq(2, n);
      chk(8'(n), 8'h08);
      // ping-pong: both stopped and single pass first, then one enable starts it
      wr(`DTD_OFF_NCTL, 8'h40);
      wr(`DTD_OFF_CCTL, 8'h04);
      wr(`DTD_OFF_NCTL, 8'hc0);
      wait_irq(0, n);
      wait_irq(0, n);
      chk(8'(n), 8'h09);
      wr(`DTD_OFF_WCTL, 8'h84);
      wr(`DTD_OFF_CCTL, 8'h84);
      pulse(8'h02);
      repeat (20) @(negedge clock_i);
      rc(`DTD_OFF_CCTL, 8'h01, 8'h00);
      pulse(8'h0c);
      wait_irq(1, n);
      rc(`DTD_OFF_CCTL, 8'h01, 8'h01);
      wr(`DTD_OFF_CCTL, 8'h85);
      rc(`DTD_OFF_CCTL, 8'h01, 8'h00);
      wr(`DTD_OFF_WCTL, 8'h00);
      wr(`DTD_OFF_CCTL, 8'h40);
      @(negedge clock_i);
      chk({7'h00, p36}, 8'h01);
      for (int m = 0; m < 2; m++)
      begin
         wr(`DTD_OFF_P3M, 8'(m << 1));
         repeat (4) @(negedge clock_i);
         chk({7'h00, pirq}, 8'(1 - m));
      end
      end_of_test();
   end
endmodule
`default_nettype wire
